// *** src/afpm_fifo.sv ***
// Package of shared constants and types, plus the sample FIFO.
// Assumes one clock domain; the converter core writes, framing logic reads.
`timescale 1ns/1ps
package afpm_pkg;
  // ------------------------------------------------------------
  // Frame edge counts
  // ------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam logic [5:0] EDGE_PD_MIN = 6'h02;
  localparam logic [5:0] EDGE_AWAKE = 6'h0a;
  localparam logic [5:0] EDGE_WORD = 6'h10;
  localparam logic [5:0] EDGE_LAST = 6'h1f;
  localparam logic [5:0] EDGE_END = 6'h20;
  localparam logic [5:0] CNT_RST = 6'h00;
  // ------------------------------------------------------------
  // Word layout and buffer sizing
  // ------------------------------------------------------------
  localparam int RES_W = 12;
  localparam int FRAME_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam logic ID_FIRST = 1'b0;
  localparam logic ID_SECOND = 1'b1;
  localparam logic LEAD_ZERO = 1'b0;
  localparam logic [2:0] SYNC_RST = 3'h7;
  // Power modes, one-hot
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_PARTIAL = 3'b010,
    MODE_FULL = 3'b100
  } afpm_mode_type;
  // Frame sequencer states, one-hot
  typedef enum logic [2:0] {
    FR_IDLE = 3'b001,
    FR_SHIFT = 3'b010,
    FR_HOLD = 3'b100
  } afpm_frame_type;
  // One simultaneous result pair with its status
  typedef struct packed {
    logic rangeBit;
    logic chanBit;
    logic [RES_W-1:0] resA;
    logic [RES_W-1:0] resB;
  } afpm_sample_type;
  localparam int SAMPLE_W = $bits(afpm_sample_type);
endpackage

module afpm_fifo
  import afpm_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] inWord, // Write data
  input wire logic inValid, // Write request
  output logic inReady, // Space available
  output logic [WIDTH-1:0] outWord, // Head data
  output logic outValid, // Head present
  input wire logic outReady // Head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  wire doWrite;
  wire doRead;
  // ------------------------------------------------------------
  // Full and empty from pointers with a wrap bit
  // ------------------------------------------------------------
  assign inReady = (wrPtr_r[AW] == rdPtr_r[AW]) || (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]);
  assign outValid = (wrPtr_r != rdPtr_r);
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outWord = mem[rdPtr_r[AW-1:0]];
  // Storage has no reset; only pointers need a defined value
  always_ff @(posedge clk)
  begin
    if (doWrite)
      mem[wrPtr_r[AW-1:0]] <= inWord;
  end
  // Pointer update
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (doRead)
        rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule

// *** src/afpm_frame_ctrl.sv ***
// Conversion framing and power-mode control of a dual serial ADC.
// Assumes frame select and serial clock are pins from an external master,
// slow against clk, and that the converter core pushes result pairs.
// Function
// - Frame select falling starts conversion; count serial falls for the frame.
// - Release between tenth and sixteenth fall: stay powered, abort, tri-state.
// - One result takes sixteen serial cycles; master supplies them.
// - After sixteen cycles the line keeps driving while select stays low.
// - Another sixteen cycles shift the other converter's result on the same line.
// - Status bits before each result name the producing converter.
// - Tri-state the line on the thirty-second fall even if select stays low.
// - Release before the thirty-second fall tri-states at once.
// - Release between second and tenth fall: partial power-down, abort, tri-state.
// - Release before second fall keeps normal mode, ignoring glitches.
// - In partial power-down a frame start begins power-up as dummy frame.
// - Powered after the dummy frame; dummy data is marked invalid.
// - Dummy release between second and tenth fall enters full power-down.
// - Dummy release before second fall returns to partial power-down.
// - Word is leading zero, three status bits, twelve result bits, MSB first.
// - Converter identity bit is 0 for first, 1 for second converter.
`timescale 1ns/1ps
module afpm_frame_ctrl
  import afpm_pkg::*;
(
  input wire logic clk, // 200 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire logic sclkPin, // Serial clock pin
  input wire logic frameSelNPin, // Frame select pin, active low
  input wire logic rangePin, // Input range select pin
  input wire logic chanSelPin, // Channel select pin
  input wire afpm_sample_type sampleIn, // Result pair from core
  input wire logic sampleValid, // Result pair offered
  output logic sampleReady, // Buffer can take it
  output logic convStart, // Pulse: sample and convert
  output logic convAbort, // Pulse: conversion cut short
  output logic convRange, // Range latched at frame start
  output logic convChan, // Channel latched at frame start
  output afpm_mode_type powerMode, // Current power mode
  output logic dataValid, // Frame carries valid data
  output logic resultLineAOut, // Result line A data
  output logic resultLineAOe, // Result line A driven
  output logic resultLineBOut, // Result line B data
  output logic resultLineBOe // Result line B driven
);
  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [2:0] sclkSync_r;
  logic [2:0] selSync_r;
  logic [1:0] rangeSync_r;
  logic [1:0] chanSync_r;
  wire sclkFall;
  wire selFall;
  wire selRise;
  // Stage 0 feeds only stage 1; edges compare stages 1 and 2
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclkSync_r <= SYNC_RST;
      selSync_r <= SYNC_RST;
      rangeSync_r <= '0;
      chanSync_r <= '0;
    end
    else
    begin
      sclkSync_r <= {sclkSync_r[1:0], sclkPin};
      selSync_r <= {selSync_r[1:0], frameSelNPin};
      rangeSync_r <= {rangeSync_r[0], rangePin};
      chanSync_r <= {chanSync_r[0], chanSelPin};
    end
  end
  assign sclkFall = sclkSync_r[2] && !sclkSync_r[1];
  assign selFall = selSync_r[2] && !selSync_r[1];
  assign selRise = !selSync_r[2] && selSync_r[1];

  // ------------------------------------------------------------
  // Result buffer between converter core and framing
  // ------------------------------------------------------------
  wire [SAMPLE_W-1:0] headWord;
  wire headValid;
  wire headPop;
  afpm_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inWord(sampleIn),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outWord(headWord),
    .outValid(headValid),
    .outReady(headPop)
  );
  afpm_sample_type head;
  assign head = afpm_sample_type'(headWord);

  // ------------------------------------------------------------
  // Frame sequencer and mode state
  // ------------------------------------------------------------
  afpm_frame_type frame_r;
  afpm_frame_type frame_nxt;
  afpm_mode_type mode_r;
  afpm_mode_type mode_nxt;
  logic [CNT_W-1:0] edgeCnt_r;
  logic dummy_r;
  logic [FRAME_W-1:0] shiftA_r;
  logic [FRAME_W-1:0] shiftB_r;
  logic oe_r;
  logic valid_r;
  logic start_r;
  logic abort_r;
  logic range_r;
  logic chan_r;
  wire inFrame;
  wire lastFall;
  wire cntEarly;
  wire cntMid;
  wire isDummy;
  wire [FRAME_W-1:0] wordA;
  wire [FRAME_W-1:0] wordB;

  assign inFrame = (frame_r != FR_IDLE);
  // Falls only shift while words are still going out
  assign lastFall = (frame_r == FR_SHIFT) && sclkFall && (edgeCnt_r == EDGE_LAST);
  assign cntEarly = (edgeCnt_r < EDGE_PD_MIN);
  assign cntMid = (edgeCnt_r < EDGE_AWAKE);
  // dummy frame
  // Any frame begun outside normal mode is a power-up frame
  assign isDummy = (mode_r != MODE_NORMAL);
  // Pop only for a real conversion; a dummy leaves results queued
  assign headPop = selFall && !isDummy && headValid;

  assign wordA = {LEAD_ZERO, head.rangeBit, head.chanBit, ID_FIRST, head.resA,
                  LEAD_ZERO, head.rangeBit, head.chanBit, ID_SECOND, head.resB};
  assign wordB = {LEAD_ZERO, head.rangeBit, head.chanBit, ID_SECOND, head.resB,
                  LEAD_ZERO, head.rangeBit, head.chanBit, ID_FIRST, head.resA};

  // Frame state: start on select low, stop on release or after 32 falls
  always_comb
  begin
    frame_nxt = frame_r;
    case (frame_r)
      FR_IDLE:
        if (selFall)
          frame_nxt = FR_SHIFT;
      FR_SHIFT:
        if (selRise)
          frame_nxt = FR_IDLE;
        else if (lastFall)
          frame_nxt = FR_HOLD;
      FR_HOLD:
        if (selRise)
          frame_nxt = FR_IDLE;
      default:
        frame_nxt = FR_IDLE;
    endcase
  end

  // mode on release
  // Release count picks the new mode; nothing else moves it
  always_comb
  begin
    mode_nxt = mode_r;
    if (selRise && inFrame && !cntEarly)
      mode_nxt = cntMid ? (dummy_r ? MODE_FULL : MODE_PARTIAL) : MODE_NORMAL;
  end

  // Edge count saturates so idling low cannot wrap it
  // frame count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      edgeCnt_r <= CNT_RST;
    else if (selFall)
      edgeCnt_r <= CNT_RST;
    else if (inFrame && sclkFall && edgeCnt_r != EDGE_END)
      edgeCnt_r <= edgeCnt_r + 1'b1;
  end

  // State, mode and frame flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_r <= FR_IDLE;
      mode_r <= MODE_NORMAL;
      dummy_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      frame_r <= frame_nxt;
      mode_r <= mode_nxt;
      if (selFall)
      begin
        dummy_r <= isDummy;
        valid_r <= !isDummy && headValid;
      end
    end
  end

  // sample at frame start
  // Range and channel are caught at the select edge for the core
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_r <= 1'b0;
      abort_r <= 1'b0;
      range_r <= 1'b0;
      chan_r <= 1'b0;
    end
    else
    begin
      start_r <= selFall;
      abort_r <= selRise && inFrame && (edgeCnt_r < EDGE_WORD);
      if (selFall)
      begin
        range_r <= rangeSync_r[1];
        chan_r <= chanSync_r[1];
      end
    end
  end

  // one fall per bit
  // Shifting one 32-bit frame makes the other result trail the first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shiftA_r <= '0;
      shiftB_r <= '0;
    end
    else if (selFall)
    begin
      shiftA_r <= wordA;
      shiftB_r <= wordB;
    end
    else if (frame_r == FR_SHIFT && sclkFall)
    begin
      shiftA_r <= {shiftA_r[FRAME_W-2:0], LEAD_ZERO};
      shiftB_r <= {shiftB_r[FRAME_W-2:0], LEAD_ZERO};
    end
  end

  // drive while select low, from frame start to release or last fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_r <= 1'b0;
    else if (selFall)
      oe_r <= 1'b1;
    else if (selRise || lastFall)
      oe_r <= 1'b0;
  end

  assign convStart = start_r;
  assign convAbort = abort_r;
  assign convRange = range_r;
  assign convChan = chan_r;
  assign powerMode = mode_r;
  assign dataValid = valid_r;
  assign resultLineAOut = shiftA_r[FRAME_W-1];
  assign resultLineBOut = shiftB_r[FRAME_W-1];
  assign resultLineAOe = oe_r;
  assign resultLineBOe = oe_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence idSlotFirst;
    frame_r == FR_SHIFT && sclkFall && edgeCnt_r == 6'h02;
  endsequence
  sequence idSlotSecond;
    frame_r == FR_SHIFT && sclkFall && edgeCnt_r == 6'h12 && !selRise;
  endsequence
  sequence releaseIn(logic [5:0] lo, logic [5:0] hi);
    selRise && inFrame && edgeCnt_r >= lo && edgeCnt_r < hi;
  endsequence

  chk_start_drive: assert property (
    selFall |=> resultLineAOe && resultLineBOe && !resultLineAOut && edgeCnt_r == 6'h00)
    else $error("lines not driven with leading zero after frame start");
  chk_release_off: assert property (
    selRise |=> !resultLineAOe && !resultLineBOe)
    else $error("lines still driven after release");
  chk_end_off: assert property (
    lastFall && !selRise |=> !resultLineAOe ##1 !resultLineAOe)
    else $error("line driven past the last fall");
  chk_hold_drive: assert property (
    frame_r == FR_SHIFT && edgeCnt_r >= 6'h10 && !selRise && !lastFall |=> resultLineAOe)
    else $error("line dropped while select low");
  chk_id_first: assert property (
    idSlotFirst |=> resultLineAOut == 1'b0 && resultLineBOut == 1'b1)
    else $error("first identity bit wrong");
  chk_id_second: assert property (
    idSlotSecond |=> resultLineAOut == 1'b1 && resultLineBOut == 1'b0)
    else $error("second identity bit wrong");
  chk_partial_entry: assert property (
    releaseIn(6'h02, 6'h0a) and !dummy_r |=> powerMode == MODE_PARTIAL && convAbort)
    else $error("no partial power-down");
  chk_full_entry: assert property (
    releaseIn(6'h02, 6'h0a) and dummy_r |=> powerMode == MODE_FULL)
    else $error("no full power-down");
  chk_glitch_keep: assert property (
    releaseIn(6'h00, 6'h02) |=> powerMode == $past(powerMode))
    else $error("mode moved on a glitch");
  chk_stay_up: assert property (
    releaseIn(6'h0a, 6'h21) |=> powerMode == MODE_NORMAL)
    else $error("not powered after late release");
  chk_mode_hold: assert property (
    !selRise |=> $stable(powerMode))
    else $error("mode changed without release");
endmodule

// *** test/afpm_serial_master.sv ***
// Behavioural serial master: frame select and serial clock, captures both lines.
// Assumes the bench clock paces it; pins move 1 ns after a rising edge.
`timescale 1ns/1ps
module afpm_serial_master (
  input wire logic clk, // Bench clock
  output logic sclkPin, // Serial clock, still high outside frames
  output logic frameSelNPin, // Frame select, active low
  input wire logic lineA, // Result line A as seen on the wire
  input wire logic lineB, // Result line B as seen on the wire
  input wire logic oeA // Result line A driven
);
  // ------------------------------------------------------------
  // Frame driver
  // ------------------------------------------------------------
  localparam int HALF = 4; // Clocks per serial phase, above the 2-clock minimum
  localparam int GAP = 12; // Quiet clocks after release

  initial
  begin
    sclkPin = 1'b1;
    frameSelNPin = 1'b1;
  end

  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bits are taken just before the fall that moves the line on
  task automatic frame(input int n, output logic [31:0] a, output logic [31:0] b,
    output logic oeAfter);
    a = 32'h0;
    b = 32'h0;
    frameSelNPin = 1'b0;
    waitClk(2 * HALF);
    for (int k = 0; k < n; k++)
    begin
      a[31-k] = lineA;
      b[31-k] = lineB;
      sclkPin = 1'b0;
      waitClk(HALF);
      sclkPin = 1'b1;
      waitClk(HALF);
    end
    oeAfter = oeA;
    frameSelNPin = 1'b1;
    waitClk(GAP);
  endtask
endmodule

// *** test/tb_adc_frame_power_mode_control.sv ***
// Self-checking bench for the framing and power-mode block.
// Assumes afpm_pkg and the serial master model are compiled first.
`timescale 1ns/1ps
module tb_adc_frame_power_mode_control;
  import afpm_pkg::*;
  logic clk;
  logic rst_n;
  wire sclkPin;
  wire frameSelNPin;
  logic rangePin;
  logic chanSelPin;
  afpm_sample_type sampleIn;
  logic sampleValid;
  logic sampleReady;
  logic convStart;
  logic convAbort;
  logic convRange;
  logic convChan;
  afpm_mode_type powerMode;
  logic dataValid;
  logic aOut;
  logic aOe;
  logic bOut;
  logic bOe;
  wire lineA;
  wire lineB;
  int nErrors = 0;
  int nCompared = 0;
  int nStart = 0;
  int nAbort = 0;

  // ------------------------------------------------------------
  // Wiring
  // ------------------------------------------------------------
  // Released lines float, so a stray capture shows as unknown
  assign lineA = aOe ? aOut : 1'bz;
  assign lineB = bOe ? bOut : 1'bz;

  afpm_frame_ctrl u_dut (.clk(clk), .rst_n(rst_n), .sclkPin(sclkPin),
    .frameSelNPin(frameSelNPin), .rangePin(rangePin), .chanSelPin(chanSelPin),
    .sampleIn(sampleIn), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .convStart(convStart), .convAbort(convAbort), .convRange(convRange),
    .convChan(convChan), .powerMode(powerMode), .dataValid(dataValid),
    .resultLineAOut(aOut), .resultLineAOe(aOe), .resultLineBOut(bOut),
    .resultLineBOe(bOe));

  afpm_serial_master u_master (.clk(clk), .sclkPin(sclkPin),
    .frameSelNPin(frameSelNPin), .lineA(lineA), .lineB(lineB), .oeA(aOe));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulse counters
  always @(posedge clk)
  begin
    if (convStart === 1'b1) nStart++;
    if (convAbort === 1'b1) nAbort++;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic finishTest();
    $display("Comparisons %0d, mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected 32-bit stream; swap puts the second converter first
  function automatic logic [31:0] wordOf(afpm_sample_type s, logic swap);
    logic [RES_W-1:0] r1;
    logic [RES_W-1:0] r2;
    r1 = swap ? s.resB : s.resA;
    r2 = swap ? s.resA : s.resB;
    return {LEAD_ZERO, s.rangeBit, s.chanBit, swap, r1,
      LEAD_ZERO, s.rangeBit, s.chanBit, ~swap, r2};
  endfunction

  task automatic push(input afpm_sample_type s);
    int w;
    @(posedge clk);
    #1;
    sampleIn = s;
    sampleValid = 1'b1;
    w = 0;
    while (sampleReady !== 1'b1 && w < 100)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    check(32'(sampleReady), 32'h1);
    @(posedge clk);
    #1;
    sampleValid = 1'b0;
  endtask

  task automatic runMode(input int n, input afpm_mode_type m);
    logic [31:0] a;
    logic [31:0] b;
    logic oe;
    u_master.frame(n, a, b, oe);
    check(32'(powerMode), 32'(m));
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic testFull();
    afpm_sample_type s;
    logic [31:0] a;
    logic [31:0] b;
    logic oe;
    int st;
    s = '{1'b1, 1'b1, 12'ha5c, 12'h3e1};
    chanSelPin = 1'b1;
    push(s);
    st = nStart;
    u_master.frame(32, a, b, oe);
    check(a, wordOf(s, ID_FIRST));
    check(b, wordOf(s, ID_SECOND));
    check(32'(oe), 32'h0);
    check(32'(nStart - st), 32'h1);
    check({29'h0, dataValid, convRange, convChan}, 32'h7);
    check(32'(powerMode), 32'(MODE_NORMAL));
    $display("Test full frame done");
  endtask

  task automatic testAbort();
    logic [31:0] a;
    logic [31:0] b;
    logic oe;
    int ab;
    ab = nAbort;
    rangePin = 1'b0;
    chanSelPin = 1'b0;
    u_master.frame(12, a, b, oe);
    check(32'(oe), 32'h1);
    check({30'h0, convRange, convChan}, 32'h0);
    check({30'h0, aOe, bOe}, 32'h0);
    check(32'(nAbort - ab), 32'h1);
    check(32'(powerMode), 32'(MODE_NORMAL));
    runMode(1, MODE_NORMAL);
    $display("Test abort and glitch done");
  endtask

  task automatic testPower();
    afpm_sample_type s;
    logic [31:0] a;
    logic [31:0] b;
    logic oe;
    runMode(5, MODE_PARTIAL);
    runMode(1, MODE_PARTIAL);
    runMode(12, MODE_NORMAL);
    check(32'(dataValid), 32'h0);
    runMode(5, MODE_PARTIAL);
    runMode(5, MODE_FULL);
    s = '{1'b0, 1'b1, 12'h0f3, 12'h801};
    push(s);
    runMode(12, MODE_NORMAL);
    u_master.frame(16, a, b, oe);
    check(a, wordOf(s, ID_FIRST) & 32'hffff0000);
    check(32'(dataValid), 32'h1);
    $display("Test power modes done");
  endtask

  task automatic testFifo();
    afpm_sample_type s;
    logic [31:0] a;
    logic [31:0] b;
    logic oe;
    for (int i = 0; i < FIFO_DEPTH; i++)
      push('{i[0], i[1], 12'(i * 273), 12'(4095 - i)});
    check(32'(sampleReady), 32'h0);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      s = '{i[0], i[1], 12'(i * 273), 12'(4095 - i)};
      u_master.frame(16, a, b, oe);
      check(a, wordOf(s, ID_FIRST) & 32'hffff0000);
      check(32'(oe), 32'h1);
    end
    check(32'(sampleReady), 32'h1);
    u_master.frame(3, a, b, oe);
    check(32'(dataValid), 32'h0);
    $display("Test buffer fill and drain done");
  endtask

  // Mid-run reset must clear mode, buffer and latched frame flags
  task automatic testReset();
    afpm_sample_type s;
    logic [31:0] a;
    logic [31:0] b;
    logic oe;
    s = '{1'b1, 1'b0, 12'h123, 12'h456};
    push(s);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check(32'(powerMode), 32'(MODE_NORMAL));
    check({29'h0, dataValid, convRange, convChan}, 32'h0);
    repeat (4) @(posedge clk);
    #1;
    u_master.frame(16, a, b, oe);
    check(32'(dataValid), 32'h0);
    check(32'(powerMode), 32'(MODE_NORMAL));
    $display("Test mid-run reset done");
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    rangePin = 1'b1;
    chanSelPin = 1'b0;
    sampleIn = '0;
    sampleValid = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    testFull();
    testAbort();
    testPower();
    testFifo();
    testReset();
    finishTest();
  end

  // Whole run needs about 3600 clocks
  initial
  begin
    repeat (40000) @(posedge clk);
    nErrors++;
    finishTest();
  end
endmodule
